// file: logic/dsbu_pkg.sv
// Constants for the debug state and breakpoint unit: register indexes,
// field positions, reset values and cause codes.
// Assumes a 32-bit AXI4-Lite slave where byte address = index * 4.
package dsbu_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MEMSIZE = 8'h0c;
  localparam logic [7:0] IDX_SST = 8'h10;
  localparam logic [7:0] IDX_PCS = 8'h11;
  localparam logic [7:0] IDX_SPS = 8'h12;
  localparam logic [7:0] IDX_OP_THR = 8'h13;
  localparam logic [7:0] IDX_OP_REG = 8'h14;
  localparam logic [7:0] IDX_CAUSE = 8'h15;
  localparam logic [7:0] IDX_CDATA = 8'h16;
  localparam logic [7:0] IDX_STOP = 8'h18;
  localparam logic [7:0] IDX_SCR = 8'h20;
  localparam logic [7:0] IDX_IBA = 8'h30;
  localparam logic [7:0] IDX_IBC = 8'h40;
  localparam logic [7:0] IDX_DWA1 = 8'h50;
  localparam logic [7:0] IDX_DWA2 = 8'h60;

  // ----------------------------------------------------------------
  // Sizes, fields and values
  // ----------------------------------------------------------------
  localparam int NUM_BP = 4;
  localparam int NUM_SCR = 8;
  localparam logic [31:0] MEM_SIZE_BYTES = 32'h0004_0000;
  localparam logic [31:0] MEMSIZE_MASK = 32'hffff_fffc;
  localparam logic [10:0] SST_WR_MASK = 11'h6df;
  localparam logic [10:0] SST_KEEP = 11'h7df;
  localparam logic [10:0] SST_RST = 11'h000;
  localparam int IBC_EN_BIT = 0;
  localparam int IBC_COND_BIT = 1;
  localparam int IBC_TEN_LSB = 16;
  localparam int CAUSE_NUM_LSB = 16;
  localparam int CAUSE_THR_LSB = 8;
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_HOST = 3'h1;
  localparam logic [2:0] CAUSE_CALL = 3'h2;
  localparam logic [2:0] CAUSE_IBREAK = 3'h3;
  localparam logic [2:0] CAUSE_DWATCH = 3'h4;
  localparam logic [2:0] CAUSE_RWATCH = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DSBU_WR_IDLE = 2'h1,
    DSBU_WR_RESP = 2'h2
  } dsbu_wr_st_t;

endpackage

// file: logic/dsbu_debug_unit.sv
// Debug state and breakpoint unit for one multi-threaded tile.
// Assumes the core supplies issue, entry and watchpoint events in mclk.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps

// Function
// - Read-only memory size in bits 31:2, bits 1:0 read zero.
// - Capture the thread status word with its flag bits at debugger entry.
// - Status copy also holds space id, kernel issue mode, read-only issue mode.
// - Capture saved program counter at entry; software may read and write it.
// - Capture saved stack pointer at entry; software may read and write it.
// - Thread and register operands, 8 and 5 bits, drive the register fetch.
// - Three-bit cause code, reset zero, codes one to five.
// - Two-bit breakpoint number, lowest wins, zero for host and call.
// - Eight-bit thread number of the cause, zero for host requests.
// - Data watchpoint stores the access address in the cause data word.
// - Resource watchpoint stores the resource id in the same data word.
// - Eight-bit stop mask keeps marked threads halted outside debug mode.
// - Eight scratch words shared with the tile configuration port.
// - Four instruction breakpoints with 32-bit addresses raise debug interrupts.
// - Per-thread enable field, reset zero, limits each breakpoint.
// - Condition bit selects break on equal or on not equal.
// - Enable bit, reset zero; a disabled breakpoint never fires.
// - Four first data watchpoint addresses in a contiguous group.
// - Four second data watchpoint addresses, sixteen words after the first ones.
module dsbu_debug_unit
  import dsbu_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic in_debug,
  input wire logic dbg_entry,
  input wire logic [10:0] entry_status,
  input wire logic [31:0] entry_pc,
  input wire logic [31:0] entry_sp,
  input wire logic issue_valid,
  input wire logic [2:0] issue_thread,
  input wire logic [31:0] issue_pc,
  input wire logic host_req,
  input wire logic call_req,
  input wire logic [2:0] call_thread,
  input wire logic [3:0] dw_hit,
  input wire logic [2:0] dw_thread,
  input wire logic [31:0] dw_addr,
  input wire logic [3:0] rw_hit,
  input wire logic [2:0] rw_thread,
  input wire logic [31:0] rw_id,
  output logic debug_irq,
  output logic [7:0] thread_stop,
  output logic [7:0] fetch_thread,
  output logic [4:0] fetch_reg,
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_idx,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  dsbu_wr_st_t wr_st_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [11:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [10:0] sst_ff;
  logic [31:0] pcs_ff;
  logic [31:0] sps_ff;
  logic [7:0] op_thr_ff;
  logic [4:0] op_reg_ff;
  logic [2:0] cause_code_ff;
  logic [1:0] cause_num_ff;
  logic [7:0] cause_thr_ff;
  logic [31:0] cdata_ff;
  logic [7:0] stop_ff;
  logic [31:0] scr_ff [NUM_SCR];
  logic [31:0] iba_ff [NUM_BP];
  logic ibc_en_ff [NUM_BP];
  logic ibc_cond_ff [NUM_BP];
  logic [7:0] ibc_ten_ff [NUM_BP];
  logic [31:0] dwa1_ff [NUM_BP];
  logic [31:0] dwa2_ff [NUM_BP];
  logic [31:0] cfg_rdata_ff;

  logic do_wr;
  logic [7:0] widx;
  logic [31:0] wm;
  logic [3:0] ib_hit;
  logic [1:0] ib_low;
  logic [2:0] ev_code;
  logic [1:0] ev_num;
  logic [7:0] ev_thr;
  logic ev_data_we;
  logic [31:0] ev_data;
  logic capture;
  logic [31:0] rd_val;
  logic rd_ok;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Lowest set bit wins when several comparators fire at once.
  function automatic logic [1:0] lowest(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    if (v[0]) r = 2'h0;
    else if (v[1]) r = 2'h1;
    else if (v[2]) r = 2'h2;
    else if (v[3]) r = 2'h3;
    return r;
  endfunction

  // Byte-lane merge of write data into the old register value.
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // An address is mapped only below 0x400 and at a listed index.
  function automatic logic mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    mapped = (a[11:10] == 2'h0) && ((i == IDX_MEMSIZE) ||
      (i >= IDX_SST && i <= IDX_CDATA) || (i == IDX_STOP) ||
      (i >= IDX_SCR && i < IDX_SCR + 8'h08) ||
      (i >= IDX_IBA && i < IDX_IBA + 8'h04) ||
      (i >= IDX_IBC && i < IDX_IBC + 8'h04) ||
      (i >= IDX_DWA1 && i < IDX_DWA1 + 8'h04) ||
      (i >= IDX_DWA2 && i < IDX_DWA2 + 8'h04));
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------

  // Address and data are caught separately, in either order.
  assign s_axi_awready = !aw_got_ff;
  assign s_axi_wready = !w_got_ff;
  assign s_axi_bvalid = (wr_st_ff == DSBU_WR_RESP);
  assign s_axi_bresp = bresp_ff;
  assign do_wr = ce && aw_got_ff && w_got_ff && (wr_st_ff == DSBU_WR_IDLE);
  assign widx = aw_addr_ff[11:10] == 2'h0 ? aw_addr_ff[9:2] : 8'hff;
  assign wm = w_data_ff;

  // Holding slots; they free only once the response is taken.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && !aw_got_ff)
      begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_ff)
      begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
    end
  end

  // Response state: one write in flight at a time.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wr_st_ff <= DSBU_WR_IDLE;
      bresp_ff <= RESP_OKAY;
    end
    else if (ce)
    begin
      case (wr_st_ff)
        DSBU_WR_IDLE:
        begin
          if (do_wr)
          begin
            wr_st_ff <= DSBU_WR_RESP;
            bresp_ff <= mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        DSBU_WR_RESP:
        begin
          if (s_axi_bready) wr_st_ff <= DSBU_WR_IDLE;
        end
        default: wr_st_ff <= DSBU_WR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------

  // Read value is sampled at the address handshake; reserved bits are zero.
  always_comb
  begin
    rd_val = 32'h0;
    rd_ok = mapped(s_axi_araddr);
    case (s_axi_araddr[9:2])
      IDX_MEMSIZE: rd_val = MEM_SIZE_BYTES & MEMSIZE_MASK;
      IDX_SST: rd_val = {21'h0, sst_ff};
      IDX_PCS: rd_val = pcs_ff;
      IDX_SPS: rd_val = sps_ff;
      IDX_OP_THR: rd_val = {24'h0, op_thr_ff};
      IDX_OP_REG: rd_val = {27'h0, op_reg_ff};
      IDX_CAUSE: rd_val = {14'h0, cause_num_ff, cause_thr_ff, 5'h0, cause_code_ff};
      IDX_CDATA: rd_val = cdata_ff;
      IDX_STOP: rd_val = {24'h0, stop_ff};
      default:
      begin
        for (int i = 0; i < NUM_SCR; i++)
        begin
          if (s_axi_araddr[9:2] == IDX_SCR + 8'(i)) rd_val = scr_ff[i];
        end
        for (int i = 0; i < NUM_BP; i++)
        begin
          if (s_axi_araddr[9:2] == IDX_IBA + 8'(i)) rd_val = iba_ff[i];
          if (s_axi_araddr[9:2] == IDX_IBC + 8'(i))
            rd_val = {8'h0, ibc_ten_ff[i], 14'h0, ibc_cond_ff[i], ibc_en_ff[i]};
          if (s_axi_araddr[9:2] == IDX_DWA1 + 8'(i)) rd_val = dwa1_ff[i];
          if (s_axi_araddr[9:2] == IDX_DWA2 + 8'(i)) rd_val = dwa2_ff[i];
        end
      end
    endcase
    if (!rd_ok) rd_val = 32'h0;
  end

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Unmapped reads answer SLVERR with zero data.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && !rvalid_ff)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_val;
        rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Instruction breakpoints
  // ----------------------------------------------------------------

  // Each comparator looks at the issuing instruction in its issue cycle.
  for (genvar gi = 0; gi < NUM_BP; gi++)
  begin : g_bp
    logic pc_eq;
    assign pc_eq = (issue_pc == iba_ff[gi]);
    assign ib_hit[gi] = issue_valid && ibc_en_ff[gi]
      && ibc_ten_ff[gi][issue_thread]
      && (ibc_cond_ff[gi] ? !pc_eq : pc_eq);

    // Breakpoint and watchpoint address words for this entry.
    always_ff @(posedge mclk)
    begin
      if (srst)
      begin
        iba_ff[gi] <= 32'h0;
        ibc_en_ff[gi] <= 1'b0;
        ibc_cond_ff[gi] <= 1'b0;
        ibc_ten_ff[gi] <= 8'h00;
        dwa1_ff[gi] <= 32'h0;
        dwa2_ff[gi] <= 32'h0;
      end
      else if (do_wr)
      begin
        if (widx == IDX_IBA + 8'(gi)) iba_ff[gi] <= merge(iba_ff[gi], wm, w_strb_ff);
        if (widx == IDX_IBC + 8'(gi))
        begin
          if (w_strb_ff[0]) ibc_en_ff[gi] <= wm[IBC_EN_BIT];
          if (w_strb_ff[0]) ibc_cond_ff[gi] <= wm[IBC_COND_BIT];
          if (w_strb_ff[2]) ibc_ten_ff[gi] <= wm[IBC_TEN_LSB +: 8];
        end
        if (widx == IDX_DWA1 + 8'(gi))
          dwa1_ff[gi] <= merge(dwa1_ff[gi], wm, w_strb_ff);
        if (widx == IDX_DWA2 + 8'(gi))
          dwa2_ff[gi] <= merge(dwa2_ff[gi], wm, w_strb_ff);
      end
    end
  end

  assign ib_low = lowest(ib_hit);

  // ----------------------------------------------------------------
  // Debug interrupt cause
  // ----------------------------------------------------------------

  // Host beats call beats breakpoint beats watchpoints when they coincide.
  always_comb
  begin
    ev_code = CAUSE_NONE;
    ev_num = 2'h0;
    ev_thr = 8'h00;
    ev_data_we = 1'b0;
    ev_data = 32'h0;
    if (host_req)
    begin
      ev_code = CAUSE_HOST;
    end
    else if (call_req)
    begin
      ev_code = CAUSE_CALL;
      ev_thr = {5'h00, call_thread};
    end
    else if (|ib_hit)
    begin
      ev_code = CAUSE_IBREAK;
      ev_num = ib_low;
      ev_thr = {5'h00, issue_thread};
    end
    else if (|dw_hit)
    begin
      ev_code = CAUSE_DWATCH;
      ev_num = lowest(dw_hit);
      ev_thr = {5'h00, dw_thread};
      ev_data_we = 1'b1;
      ev_data = dw_addr;
    end
    else if (|rw_hit)
    begin
      ev_code = CAUSE_RWATCH;
      ev_num = lowest(rw_hit);
      ev_thr = {5'h00, rw_thread};
      ev_data_we = 1'b1;
      ev_data = rw_id;
    end
  end

  // Raised in the cycle of the event so the instruction cannot complete.
  assign debug_irq = (ev_code != CAUSE_NONE) && !in_debug;
  assign capture = ce && debug_irq;

  // A captured event wins over a software write in the same cycle.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cause_code_ff <= CAUSE_NONE;
      cause_num_ff <= 2'h0;
      cause_thr_ff <= 8'h00;
      cdata_ff <= 32'h0;
    end
    else if (capture)
    begin
      cause_code_ff <= ev_code;
      cause_num_ff <= ev_num;
      cause_thr_ff <= ev_thr;
      if (ev_data_we) cdata_ff <= ev_data;
    end
    else if (do_wr)
    begin
      if (widx == IDX_CAUSE && w_strb_ff[0]) cause_code_ff <= wm[2:0];
      if (widx == IDX_CAUSE && w_strb_ff[1]) cause_thr_ff <= wm[CAUSE_THR_LSB +: 8];
      if (widx == IDX_CAUSE && w_strb_ff[2]) cause_num_ff <= wm[CAUSE_NUM_LSB +: 2];
      if (widx == IDX_CDATA) cdata_ff <= merge(cdata_ff, wm, w_strb_ff);
    end
  end

  // ----------------------------------------------------------------
  // Saved state copies
  // ----------------------------------------------------------------

  // Entry capture wins over software; the issue-mode bit is not writable.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sst_ff <= SST_RST;
      pcs_ff <= 32'h0;
      sps_ff <= 32'h0;
    end
    else if (ce && dbg_entry)
    begin
      sst_ff <= entry_status & SST_KEEP;
      pcs_ff <= entry_pc;
      sps_ff <= entry_sp;
    end
    else if (do_wr)
    begin
      if (widx == IDX_SST)
        sst_ff <= (sst_ff & ~SST_WR_MASK) |
          (11'(merge({21'h0, sst_ff}, wm, w_strb_ff & 4'h3)) & SST_WR_MASK);
      if (widx == IDX_PCS) pcs_ff <= merge(pcs_ff, wm, w_strb_ff);
      if (widx == IDX_SPS) sps_ff <= merge(sps_ff, wm, w_strb_ff);
    end
  end

  // ----------------------------------------------------------------
  // Operands and thread stop
  // ----------------------------------------------------------------

  // Operands feed the register fetch path directly from flip-flops.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      op_thr_ff <= 8'h00;
      op_reg_ff <= 5'h00;
      stop_ff <= 8'h00;
    end
    else if (do_wr && w_strb_ff[0])
    begin
      if (widx == IDX_OP_THR) op_thr_ff <= wm[7:0];
      if (widx == IDX_OP_REG) op_reg_ff <= wm[4:0];
      if (widx == IDX_STOP) stop_ff <= wm[7:0];
    end
  end

  assign fetch_thread = op_thr_ff;
  assign fetch_reg = op_reg_ff;
  // The mask only holds threads back once debug mode is left.
  assign thread_stop = stop_ff & {8{!in_debug}};

  // ----------------------------------------------------------------
  // Scratch words
  // ----------------------------------------------------------------

  // The configuration port is checked first, so it wins a same-word collision.
  for (genvar gs = 0; gs < NUM_SCR; gs++)
  begin : g_scr
    always_ff @(posedge mclk)
    begin
      if (srst)
        scr_ff[gs] <= 32'h0;
      else if (ce && cfg_wr && cfg_idx == 3'(gs))
        scr_ff[gs] <= cfg_wdata;
      else if (do_wr && widx == IDX_SCR + 8'(gs))
        scr_ff[gs] <= merge(scr_ff[gs], wm, w_strb_ff);
    end
  end

  // Configuration reads return one cycle after the index is presented.
  always_ff @(posedge mclk)
  begin
    if (srst)
      cfg_rdata_ff <= 32'h0;
    else if (ce)
      cfg_rdata_ff <= scr_ff[cfg_idx];
  end

  assign cfg_rdata = cfg_rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  sequence s_ib_cap;
    capture && !host_req && !call_req && (|ib_hit);
  endsequence

  sequence s_host_cap;
    capture && host_req;
  endsequence

  AST_MEMSIZE_READ: assert property (
    ce && s_axi_arvalid && s_axi_arready && s_axi_araddr == {2'h0, IDX_MEMSIZE, 2'h0}
    |=> s_axi_rvalid && s_axi_rdata == (MEM_SIZE_BYTES & MEMSIZE_MASK))
    else $error("memory size read wrong");

  AST_IB_CAUSE: assert property (
    s_ib_cap |=> cause_code_ff == CAUSE_IBREAK && cause_num_ff == $past(ib_low))
    else $error("breakpoint cause not recorded");

  AST_HOST_ZERO: assert property (
    s_host_cap |=> cause_code_ff == CAUSE_HOST && cause_thr_ff == 8'h00
      && cause_num_ff == 2'h0)
    else $error("host cause fields not zero");

  AST_NO_DISABLED_HIT: assert property (
    !ibc_en_ff[0] && !ibc_en_ff[1] && !ibc_en_ff[2] && !ibc_en_ff[3] |-> ib_hit == 4'h0)
    else $error("disabled breakpoint fired");

  AST_STOP_MASK: assert property (
    !in_debug |-> thread_stop == stop_ff)
    else $error("stop mask not applied");

  AST_DW_DATA: assert property (
    capture && ev_code == CAUSE_DWATCH |=> cdata_ff == $past(dw_addr))
    else $error("watch address not stored");

  AST_ENTRY_PC: assert property (
    ce && dbg_entry ##1 !(ce && dbg_entry) |-> pcs_ff == $past(entry_pc))
    else $error("saved pc not captured");

  AST_OPREG_RSVD: assert property (
    s_axi_rvalid && $rose(s_axi_rvalid) && $past(s_axi_araddr[9:2]) == IDX_OP_REG
    |-> s_axi_rdata[31:5] == 27'h0)
    else $error("reserved bits not zero");

endmodule

// file: testbench/dsbu_axi_host.sv
// Debug software model: an AXI4-Lite master making single register accesses.
// Assumes a slave on mclk; only the bench watchdog ends a wait for an answer.
`timescale 1ns/100ps
module dsbu_axi_host
(
  input wire logic mclk,
  output logic awvalid,
  input wire logic awready,
  output logic [11:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [11:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  // Idle bus at time zero; every word is written whole.
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
  end

  // Handshakes are judged mid-cycle, since inputs only move just after an edge.
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] resp);
    logic ta, tw, tb;
    @(posedge mclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      resp = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    logic ta, tr;
    @(posedge mclk);
    araddr <= {2'h0, idx, 2'h0};
    {arvalid, rready} <= 2'h3;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge mclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
endmodule

// file: testbench/tb_debug_state_breakpoint_unit.sv
// Self-checking bench: the host model plays software, the bench plays the core.
// Assumes the unit answers AXI requests without a fixed latency.
`timescale 1ns/100ps
module tb_debug_state_breakpoint_unit
  import dsbu_pkg::*;
;
  logic mclk, srst, ce, in_debug, dbg_entry, issue_valid, host_req, call_req, debug_irq, cfg_wr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [2:0] issue_thread, call_thread, dw_thread, rw_thread, cfg_idx;
  logic [3:0] wstrb, dw_hit, rw_hit;
  logic [4:0] fetch_reg;
  logic [7:0] thread_stop, fetch_thread;
  logic [10:0] entry_status;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, entry_pc, entry_sp, issue_pc, dw_addr, rw_id, cfg_wdata, cfg_rdata;
  logic [1:0] r;
  logic [31:0] d;
  int err_total;
  int checked;

  dsbu_debug_unit dut_u (.mclk, .srst, .ce, .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .in_debug, .dbg_entry, .entry_status, .entry_pc, .entry_sp, .issue_valid, .issue_thread,
    .issue_pc, .host_req, .call_req, .call_thread, .dw_hit, .dw_thread, .dw_addr, .rw_hit,
    .rw_thread, .rw_id, .debug_irq, .thread_stop, .fetch_thread, .fetch_reg, .cfg_wr, .cfg_idx,
    .cfg_wdata, .cfg_rdata);
  dsbu_axi_host host_u (.mclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

  always #5 mclk = ~mclk;

  // ----------------------------------------
  // Shared checks and bus helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    host_u.rd(idx, d, r);
    chk($sformatf("reg %h", idx), exp, d);
  endtask
  task automatic wrt(input logic [7:0] idx, input logic [31:0] v);
    host_u.wr(idx, v, r);
    chk("bresp", 32'(RESP_OKAY), 32'(r));
  endtask
  // Events stand for one cycle; the interrupt line is judged mid-cycle.
  task automatic fire(input logic exp);
    @(negedge mclk);
    chk("debug_irq", 32'(exp), 32'(debug_irq));
    @(posedge mclk);
    {issue_valid, host_req, call_req, dw_hit, rw_hit} <= '0;
  endtask
  task automatic iss(input logic [2:0] t, input logic [31:0] pc, input logic exp);
    @(posedge mclk);
    {issue_valid, issue_thread, issue_pc} <= {1'b1, t, pc};
    fire(exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rchk(IDX_CAUSE, 32'h0);
    rchk(IDX_IBC + 8'h3, 32'h0);
    host_u.wr(IDX_MEMSIZE, '1, r);
    rchk(IDX_MEMSIZE, MEM_SIZE_BYTES & MEMSIZE_MASK);
  endtask
  // All-ones writes show which bits are kept and which read zero.
  task automatic t_regs();
    logic [7:0] ix[7] = '{IDX_OP_THR, IDX_OP_REG, IDX_SST, IDX_CAUSE, IDX_STOP, IDX_PCS, IDX_CDATA};
    logic [31:0] ex[7] = '{32'hff, 32'h1f, 32'h6df, 32'h3ff07, 32'hff, '1, '1};
    foreach (ix[k])
    begin
      wrt(ix[k], '1);
      rchk(ix[k], ex[k]);
    end
    chk("fetch", 32'h1fff, {19'h0, fetch_reg, fetch_thread});
    chk("stop", 32'hff, 32'(thread_stop));
    @(posedge mclk);
    in_debug <= 1'b1;
    @(negedge mclk);
    chk("stop in debug", 32'h0, 32'(thread_stop));
    wrt(IDX_STOP, 32'h0);
    in_debug <= 1'b0;
  endtask
  task automatic t_scratch();
    for (int k = 0; k < 8; k++)
    begin
      wrt(IDX_SCR + 8'(k), 32'h5c00_0000 + k);
      if (k < 4) wrt(IDX_IBA + 8'(k), 32'h1b00_0000 + k);
      if (k < 4) wrt(IDX_DWA1 + 8'(k), 32'hd100_0000 + k);
    end
    for (int k = 0; k < 8; k++)
    begin
      rchk(IDX_SCR + 8'(k), 32'h5c00_0000 + k);
      if (k < 4) rchk(IDX_IBA + 8'(k), 32'h1b00_0000 + k);
      if (k < 4) rchk(IDX_DWA1 + 8'(k), 32'hd100_0000 + k);
    end
    @(posedge mclk);
    {cfg_wr, cfg_idx, cfg_wdata} <= {1'b1, 3'h3, 32'hc0f1_9003};
    @(posedge mclk);
    {cfg_wr, cfg_idx} <= {1'b0, 3'h5};
    @(posedge mclk);
    @(negedge mclk);
    chk("cfg_rdata", 32'h5c00_0005, cfg_rdata);
    rchk(IDX_SCR + 8'h3, 32'hc0f1_9003);
  endtask
  task automatic t_entry();
    @(posedge mclk);
    {dbg_entry, entry_status, entry_pc, entry_sp} <= {1'b1, 11'h7ff, 32'hcafe_0010, 32'h1fff8};
    @(posedge mclk);
    dbg_entry <= 1'b0;
    rchk(IDX_SST, 32'h7df);
    rchk(IDX_PCS, 32'hcafe_0010);
    rchk(IDX_SPS, 32'h1fff8);
  endtask
  task automatic t_break();
    wrt(IDX_IBA + 8'h1, 32'h100);
    wrt(IDX_IBC + 8'h1, 32'h4_0001);
    iss(3'h2, 32'h100, 1'b1);
    rchk(IDX_CAUSE, 32'h1_0203);
    iss(3'h3, 32'h100, 1'b0);
    wrt(IDX_IBC + 8'h1, 32'h4_0003);
    iss(3'h2, 32'h104, 1'b1);
    iss(3'h2, 32'h100, 1'b0);
    wrt(IDX_IBC + 8'h1, 32'h4_0002);
    iss(3'h2, 32'h104, 1'b0);
    wrt(IDX_IBA, 32'h100);
    wrt(IDX_IBC, 32'h4_0001);
    wrt(IDX_IBC + 8'h1, 32'h4_0001);
    iss(3'h2, 32'h100, 1'b1);
    rchk(IDX_CAUSE, 32'h0203);
  endtask
  task automatic t_cause();
    @(posedge mclk);
    host_req <= 1'b1;
    fire(1'b1);
    rchk(IDX_CAUSE, 32'h1);
    {call_req, call_thread} <= 4'hd;
    fire(1'b1);
    rchk(IDX_CAUSE, 32'h0502);
    {dw_hit, dw_thread, dw_addr} <= {4'hc, 3'h6, 32'h8a40};
    fire(1'b1);
    rchk(IDX_CAUSE, 32'h2_0604);
    rchk(IDX_CDATA, 32'h8a40);
    {rw_hit, rw_thread, rw_id} <= {4'ha, 3'h1, 32'h213};
    fire(1'b1);
    rchk(IDX_CAUSE, 32'h1_0105);
    rchk(IDX_CDATA, 32'h213);
    {in_debug, host_req} <= 2'h3;
    fire(1'b0);
    in_debug <= 1'b0;
    rchk(IDX_CAUSE, 32'h1_0105);
    host_u.wr(8'h17, '1, r);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
    rchk(8'h17, 32'h0);
    chk("rresp", 32'(RESP_SLVERR), 32'(r));
  endtask

  task automatic give_verdict();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Ten reset cycles, then every scenario in turn.
  initial
  begin
    {mclk, srst, ce} = 3'h3;
    {in_debug, dbg_entry, issue_valid, host_req, call_req, cfg_wr} = '0;
    {dw_hit, rw_hit, issue_thread, call_thread, dw_thread, rw_thread, cfg_idx} = '0;
    {entry_status, entry_pc, entry_sp, issue_pc, dw_addr, rw_id, cfg_wdata} = '0;
    {err_total, checked} = '0;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_regs();
    t_scratch();
    t_entry();
    t_break();
    t_cause();
    give_verdict();
  end

  // About 300 cycles are needed; a hang is cut off far beyond.
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    give_verdict();
  end
endmodule
